// ---- hw/lcd_glyph_row.sv ----
// lcd_glyph_row: dot row of one character cell with cursor and blink
`timescale 1ns/10ps
module lcd_glyph_row
   import lcd_pkg::*;
(
   input  wire logic [7:0]   code_i,
   input  wire logic [2:0]   row_i,
   input  wire logic [4:0]   ufr_dots_i,
   input  wire logic [4:0]   rom_dots_i,
   input  wire logic         cursor_here_i,
   input  wire lcd_dctl_type dctl_i,
   input  wire logic         blink_phase_i,
   output logic      [4:0]   ufr_idx_o,
   output logic      [4:0]   dots_o
);

   wire       is_uf;
   wire [4:0] pat;
   wire       cur_line;
   wire       blink_fill;

   assign is_uf      = lcd_is_ufont(code_i);
   assign ufr_idx_o  = {code_i[1:0], row_i};
   // bit 4 is the leftmost dot, a one lights it
   assign pat        = is_uf ? ufr_dots_i :
                       (row_i == CURSOR_ROW) ? 5'h00 : rom_dots_i;
   assign cur_line   = cursor_here_i && dctl_i.cursor_on &&
                       (row_i == CURSOR_ROW);
   assign blink_fill = cursor_here_i && dctl_i.blink_on &&
                       blink_phase_i;
   // cursor ored into the eighth row, stored ones stay visible
   assign dots_o     = blink_fill ? DOTS_ALL :
                       (pat | {DOTS{cur_line}});

endmodule // lcd_glyph_row

// ---- hw/lcd_ram_map_cursor_init.sv ----
// lcd_ram_map_cursor_init: display rams, refresh scan, cursor and init
//
// Notes on behaviour
// - codes with bits 7..2 zero use user font
// - font data bits 0..4 are row dots
// - font bit one lights dot, zero dark
// - 128 icons from icon ram 60h..7fh, d0..d4
// - icon bits 5..7 accepted, never shown
// - unbacked icon crossings always driven off
// - icon ram undefined after reset; host clears
// - refresh reads independent of host writes
// - row patterns latched into segment registers
// - cursor and blink at address counter cell
// - cursor shown even for font/icon addresses
// - power-up init holds busy for 7 ms
// - reset pin low over 1.2 ms initialises
// - busy 7 ms after reset pin release
// - font address is code[1:0] then row
// - eighth row ored with cursor line
// - busy flag one while operating internally
`timescale 1ns/10ps
module lcd_ram_map_cursor_init
   import lcd_pkg::*;
#(
   parameter int INIT_BUSY = INIT_BUSY_CYC,
   parameter int RST_MIN   = RST_MIN_CYC,
   parameter int SCAN_DIV  = SCAN_DIV_DEF
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             clk_en_i,
   input  wire logic             reset_pin_n_i,
   input  wire lcd_wr_type       host_wr_i,
   input  wire logic             ac_load_i,
   input  wire logic [6:0]       ac_value_i,
   input  wire lcd_dctl_type     dctl_i,
   input  wire logic [4:0]       font_rom_dots_i,
   output logic      [7:0]       font_rom_code_o,
   output logic      [2:0]       font_rom_row_o,
   output logic      [6:0]       address_counter_o,
   output logic                  busy_flag_o,
   output logic      [NCOM-1:0]  com_o,
   output logic      [NSEG-1:0]  seg_o
);

   localparam int BW = $clog2(INIT_BUSY + 1);
   localparam int RW = $clog2(RST_MIN + 1);
   localparam int SW = $clog2(SCAN_DIV + 1);

   // ******************************************************
   // elaboration checks
   // ******************************************************
   if (INIT_BUSY < 2 || RST_MIN < 1) begin : g_bad_time
      $error("init busy or reset length too small");
   end
   if (SCAN_DIV < 2) begin : g_bad_div
      $error("scan divider must be at least 2");
   end

   // ******************************************************
   // storage
   // ******************************************************
   logic [7:0] ddr_mem  [64];
   logic [4:0] ufr_mem  [32];
   logic [4:0] icon_mem [32];

   // the busy period must be long enough to fill every display ram cell
   if (INIT_BUSY < $size(ddr_mem)) begin : g_short_clear
      $error("init busy shorter than display ram clear");
   end

   // ******************************************************
   // initialisation and busy
   // ******************************************************
   lcd_init_type  st_q;
   lcd_init_type  st_d;
   logic [BW-1:0] busy_cnt_q;
   logic [BW-1:0] busy_cnt_d;
   logic [RW-1:0] low_cnt_q;
   logic          pin_s1_q;
   logic          pin_s2_q;
   logic [5:0]    clr_idx_q;
   logic [6:0]    ac_q;
   wire           busy;
   wire           pin_trig;
   wire           busy_done;

   assign busy      = (st_q != ST_RUN);
   assign pin_trig  = !pin_s2_q && (low_cnt_q == RW'(RST_MIN));
   assign busy_done = (busy_cnt_q == BW'(INIT_BUSY - 1));

   always_comb begin
      st_d       = st_q;
      busy_cnt_d = busy_cnt_q;
      if (pin_trig) begin
         st_d = ST_HOLD;
      end else begin
         unique case (st_q)
            ST_HOLD: begin
               busy_cnt_d = '0;
               if (pin_s2_q) begin
                  st_d = ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (busy_done) begin
                  st_d = ST_RUN;
               end else begin
                  busy_cnt_d = busy_cnt_q + BW'(1);
               end
            end
            ST_RUN: begin
               st_d = ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
      end else if (clk_en_i) begin
         pin_s1_q <= reset_pin_n_i;
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_q       <= ST_BUSY;
         busy_cnt_q <= '0;
         low_cnt_q  <= '0;
      end else if (clk_en_i) begin
         st_q       <= st_d;
         busy_cnt_q <= busy_cnt_d;
         if (pin_s2_q) begin
            low_cnt_q <= '0;
         end else if (low_cnt_q != RW'(RST_MIN)) begin
            low_cnt_q <= low_cnt_q + RW'(1);
         end
      end
   end

   // ******************************************************
   // host access port
   // ******************************************************
   wire       host_ok;
   wire [1:0] space;

   assign host_ok = host_wr_i.en && !busy;
   assign space   = host_wr_i.addr[6:5];

   // host writes use their own port, refresh reads never wait on them
   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i) begin
         if (busy) begin
            ddr_mem[clr_idx_q] <= SPACE_CODE;
         end else if (host_ok && space[1] == SPACE_DDR[1]) begin
            ddr_mem[host_wr_i.addr[5:0]] <= host_wr_i.data;
         end
         if (host_ok && space == SPACE_UFR) begin
            ufr_mem[host_wr_i.addr[4:0]] <= host_wr_i.data[4:0];
         end
         // upper data bits are dropped; no reset, software clears
         if (host_ok && space == SPACE_ICON) begin
            icon_mem[host_wr_i.addr[4:0]] <= host_wr_i.data[4:0];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         clr_idx_q <= '0;
         ac_q      <= '0;
      end else if (clk_en_i) begin
         clr_idx_q <= busy ? clr_idx_q + 6'h01 : '0;
         if (busy) begin
            ac_q <= '0;
         end else if (ac_load_i) begin
            ac_q <= ac_value_i;
         end
      end
   end

   // ******************************************************
   // refresh scan
   // ******************************************************
   logic [SW-1:0]        div_q;
   logic [5:0]           row_q;
   logic [3:0]           col_q;
   logic [7:0]           code_q;
   logic                 cur_q;
   logic                 fv_q;
   logic [CHAR_SEGS-1:0] shadow_q;
   logic [BLINK_LOG2:0]  frame_q;
   logic [NCOM-1:0]      com_q;
   logic [NSEG-1:0]      seg_q;
   logic [CHAR_SEGS-1:0] icon_seg;
   logic [NSEG-1:0]      seg_d;
   wire                  tick;
   wire                  fetch;
   wire                  latch;
   wire [1:0]            line;
   wire                  char_row;
   wire [4:0]            ufr_idx;
   wire [4:0]            ufr_rd;
   wire [4:0]            dots;
   wire [1:0]            icon_col;
   wire [4:0]            ic0_idx;
   wire [4:0]            ic1_idx;

   assign tick     = (div_q == SW'(SCAN_DIV - 1));
   assign fetch    = tick && (col_q != COL_END);
   assign latch    = tick && (col_q == COL_END);
   assign line     = row_q[4:3];
   assign char_row = (row_q < ICON_ROW0);
   assign ufr_rd   = ufr_mem[ufr_idx];

   lcd_glyph_row u_glyph (
      .code_i        (code_q),
      .row_i         (row_q[2:0]),
      .ufr_dots_i    (ufr_rd),
      .rom_dots_i    (font_rom_dots_i),
      .cursor_here_i (cur_q),
      .dctl_i        (dctl_i),
      .blink_phase_i (frame_q[BLINK_LOG2]),
      .ufr_idx_o     (ufr_idx),
      .dots_o        (dots)
   );

   // icon columns cross only the even commons of each text line
   assign ic0_idx  = {line, 1'b0, row_q[2:1]};
   assign ic1_idx  = {line, 1'b1, row_q[2:1]};
   assign icon_col = row_q[0] ? 2'b00 :
                     {icon_mem[ic1_idx][0], icon_mem[ic0_idx][0]};

   // icon commons: d4..d1 of the first six bytes of the line
   always_comb begin
      icon_seg = '0;
      for (int a = 0; a < ICON_ADDRS; a++) begin
         for (int b = 0; b < ICON_BITS; b++) begin
            icon_seg[a * ICON_BITS + b] =
               icon_mem[{row_q[1:0], 3'(a)}][4 - b];
         end
      end
   end

   assign seg_d = !dctl_i.disp_on ? '0 :
                  char_row ? {1'b0, icon_col, shadow_q} :
                  {3'b000, icon_seg};

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         div_q    <= '0;
         row_q    <= '0;
         col_q    <= '0;
         code_q   <= '0;
         cur_q    <= 1'b0;
         fv_q     <= 1'b0;
         shadow_q <= '0;
         frame_q  <= '0;
         com_q    <= '0;
         seg_q    <= '0;
      end else if (clk_en_i) begin
         div_q <= tick ? '0 : div_q + SW'(1);
         fv_q  <= fetch;
         if (fetch) begin
            code_q <= ddr_mem[{line, col_q}];
            // counter values with low nibble 0..b decode to a cell, font/icon too
            cur_q  <= (ac_q[5:4] == line) && (ac_q[3:0] == col_q);
            col_q  <= col_q + 4'h1;
         end
         if (fv_q) begin
            shadow_q <= {shadow_q[CHAR_SEGS-DOTS-1:0], dots};
         end
         if (latch) begin
            seg_q <= seg_d;
            com_q <= {{(NCOM-1){1'b0}}, 1'b1} << row_q;
            col_q <= '0;
            if (row_q == LAST_ROW) begin
               row_q   <= '0;
               frame_q <= frame_q + 1'b1;
            end else begin
               row_q <= row_q + 6'h01;
            end
         end
      end
   end

   assign font_rom_code_o   = code_q;
   assign font_rom_row_o    = row_q[2:0];
   assign address_counter_o = ac_q;
   assign busy_flag_o       = busy;
   assign com_o             = com_q;
   assign seg_o             = seg_q;

   // ******************************************************
   // assertions
   // ******************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_por_busy: assert property ($past(!rst_n_i) |-> busy_flag_o)
      else $error("busy not set after power-up");
   chk_busy_len: assert property ($fell(busy_flag_o) |->
      $past(busy_cnt_q) == BW'(INIT_BUSY - 1))
      else $error("busy period length wrong");
   chk_pin_reset: assert property (pin_trig && clk_en_i |=>
      st_q == ST_HOLD && busy_flag_o)
      else $error("long reset pin low did not start init");
   chk_ufont_addr: assert property (lcd_is_ufont(code_q) |->
      ufr_idx == {code_q[1:0], row_q[2:0]})
      else $error("user font address wrong");
   chk_ufont_dots: assert property (fv_q && lcd_is_ufont(code_q)
      && !cur_q |-> dots == ufr_rd)
      else $error("user font dots not taken from ram");
   chk_cursor_line: assert property (fv_q && cur_q &&
      dctl_i.cursor_on && row_q[2:0] == CURSOR_ROW |-> dots == DOTS_ALL)
      else $error("cursor line missing");
   chk_seg_latch: assert property (latch && clk_en_i &&
      char_row && dctl_i.disp_on |=> seg_o[CHAR_SEGS-1:0] ==
      $past(shadow_q) && com_o == ({{(NCOM-1){1'b0}}, 1'b1} <<
      $past(row_q)))
      else $error("segment register not latched");
   chk_icon_unused: assert property (com_o[SCAN_ROWS-1:32] != '0
      |-> seg_o[NSEG-1:ICON_ADDRS*ICON_BITS] == '0)
      else $error("unbacked icon segment driven");
   chk_icon_mask: assert property (host_ok && clk_en_i &&
      space == SPACE_ICON |=>
      icon_mem[$past(host_wr_i.addr[4:0])] == $past(host_wr_i.data[4:0]))
      else $error("icon ram write wrong");
   chk_busy_refuse: assert property (busy && clk_en_i |=>
      ac_q == '0)
      else $error("address counter moved while busy");

   cov_pin_reset: cover property (pin_trig ##1 st_q == ST_HOLD);
   cov_cursor:    cover property (fv_q && cur_q && dctl_i.cursor_on);
   cov_icon_row:  cover property (latch && !char_row);

endmodule // lcd_ram_map_cursor_init

// ---- include/lcd_pkg.sv ----
// lcd_pkg: shared constants, types and helpers for the lcd display block
package lcd_pkg;

   // ******************************************************
   // clock and timing
   // ******************************************************
   localparam int CLK_MHZ       = 10;
   localparam int INIT_BUSY_US  = 7000;
   localparam int RST_MIN_US    = 1200;
   localparam int INIT_BUSY_CYC = INIT_BUSY_US * CLK_MHZ;
   localparam int RST_MIN_CYC   = RST_MIN_US * CLK_MHZ;
   localparam int SCAN_DIV_DEF  = 16;
   localparam int BLINK_LOG2    = 4;

   // ******************************************************
   // geometry
   // ******************************************************
   localparam int NCOM        = 37;
   localparam int NSEG        = 63;
   localparam int COLS        = 12;
   localparam int DOTS        = 5;
   localparam int CHAR_SEGS   = COLS * DOTS;
   localparam int SCAN_ROWS   = 36;
   localparam int ICON_ADDRS  = 6;
   localparam int ICON_BITS   = 4;

   localparam logic [5:0] ICON_ROW0  = 6'h20;
   localparam logic [5:0] LAST_ROW   = 6'h23;
   localparam logic [3:0] COL_END    = 4'hc;
   localparam logic [2:0] CURSOR_ROW = 3'h7;
   localparam logic [4:0] DOTS_ALL   = 5'h1f;

   // ******************************************************
   // ram map and codes
   // ******************************************************
   localparam logic [1:0] SPACE_DDR  = 2'h0;
   localparam logic [1:0] SPACE_UFR  = 2'h2;
   localparam logic [1:0] SPACE_ICON = 2'h3;
   localparam logic [6:0] ICON_BASE  = 7'h60;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [5:0] UF_MASK    = 6'h00;

   // ******************************************************
   // types
   // ******************************************************
   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } lcd_wr_type;

   typedef struct packed {
      logic disp_on;
      logic cursor_on;
      logic blink_on;
   } lcd_dctl_type;

   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_HOLD = 3'b010,
      ST_BUSY = 3'b100
   } lcd_init_type;

   // user font selected when code bits 7..2 are all zero
   function automatic logic lcd_is_ufont(input logic [7:0] code);
      return code[7:2] == UF_MASK;
   endfunction

endpackage

// ---- tb/lcd_font_rom_model.sv ----
// lcd_font_rom_model: behavioural font rom answering the composed cell
`timescale 1ns/10ps
module lcd_font_rom_model
   import lcd_pkg::*;
(
   input  wire logic [7:0] code_i,
   input  wire logic [2:0] row_i,
   output logic      [4:0] dots_o
);
   // *********************************
   // pattern: code low bits xor row
   // *********************************
   // distinct per low five code bits and row so a wrong fetch shows
   assign dots_o = code_i[4:0] ^ {2'h0, row_i};
endmodule // lcd_font_rom_model

// ---- tb/lcd_ram_map_cursor_init_test.sv ----
// lcd_ram_map_cursor_init_test: self-checking bench for the display block
`timescale 1ns/10ps
module lcd_ram_map_cursor_init_test
   import lcd_pkg::*;
;
   localparam int IB = 80;
   localparam int RM = 10;
   logic             ref_clk_i;
   logic             rst_n_i;
   logic             reset_pin_n_i;
   logic             ac_load_i;
   logic [6:0]       ac_value_i;
   lcd_wr_type       host_wr_i;
   lcd_dctl_type     dctl_i;
   logic [4:0]       rom_dots;
   logic [7:0]       rom_code;
   logic [2:0]       rom_row;
   logic [6:0]       ac;
   logic             busy;
   logic [NCOM-1:0]  com;
   logic [NSEG-1:0]  seg;
   logic [7:0]       ddr [12];
   logic [4:0]       uf [8];
   int               miscompares;
   int               checks_done;

   lcd_ram_map_cursor_init #(.INIT_BUSY(IB), .RST_MIN(RM), .SCAN_DIV(2))
   i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
      .reset_pin_n_i(reset_pin_n_i), .host_wr_i(host_wr_i),
      .ac_load_i(ac_load_i), .ac_value_i(ac_value_i), .dctl_i(dctl_i),
      .font_rom_dots_i(rom_dots), .font_rom_code_o(rom_code),
      .font_rom_row_o(rom_row), .address_counter_o(ac),
      .busy_flag_o(busy), .com_o(com), .seg_o(seg));

   lcd_font_rom_model i_rom (.code_i(rom_code), .row_i(rom_row),
      .dots_o(rom_dots));

   // *********************************
   // helpers
   // *********************************
   task automatic check(string what, logic [62:0] exp, logic [62:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic wr(logic [6:0] a, logic [7:0] d);
      @(posedge ref_clk_i);
      host_wr_i <= '{1'b1, a, d};
      @(posedge ref_clk_i);
      host_wr_i.en <= 1'b0;
   endtask

   task automatic load_ac(logic [6:0] v);
      @(posedge ref_clk_i);
      ac_load_i <= 1'b1;
      ac_value_i <= v;
      @(posedge ref_clk_i);
      ac_load_i <= 1'b0;
      @(negedge ref_clk_i);
      check("address_counter", 63'(v), 63'(ac));
   endtask

   task automatic wait_busy(output int n);
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(negedge ref_clk_i);
         n++;
      end
   endtask

   task automatic wait_row(int r);
      int i;
      for (i = 0; i < 3000 && com !== (37'h1 << r); i++)
         @(negedge ref_clk_i);
      check("com_select", 63'(37'h1 << r), 63'(com));
   endtask

   function automatic logic [62:0] text_row(int r, int cur);
      logic [62:0] s;
      logic [4:0]  d;
      s = '0;
      s[61] = (r == 4);
      for (int c = 0; c < 12; c++) begin
         if (ddr[c][7:2] == 6'h00) d = uf[r];
         else d = (r == 7) ? 5'h00 : ddr[c][4:0] ^ 5'(r);
         if (c == cur && r == 7) d = d | 5'h1f;
         s[59-5*c -: 5] = d;
      end
      return s;
   endfunction

   task automatic t_text(int cur);
      for (int r = 0; r < 8; r++) begin
         wait_row(r);
         check("text_row", text_row(r, cur), seg);
      end
   endtask

   // *********************************
   // scenarios
   // *********************************
   task automatic t_power_up();
      int n;
      @(negedge ref_clk_i);
      check("busy_in_reset", 63'h1, 63'(busy));
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      wait_busy(n);
      check("init_busy_len", 63'h1, 63'(n >= IB - 1 && n <= IB + 2));
   endtask

   task automatic t_font();
      for (int c = 0; c < 12; c++) ddr[c] = 8'h20;
      ddr[0] = 8'h02;
      ddr[1] = 8'h41;
      for (int r = 0; r < 8; r++) begin
         uf[r] = 5'(3 * r + 1);
         wr(7'h50 + 7'(r), {3'h7, uf[r]});
      end
      wr(7'h00, ddr[0]);
      wr(7'h01, ddr[1]);
   endtask

   task automatic t_icons();
      for (int a = 0; a < 32; a++) wr(7'h60 + 7'(a), 8'h00);
      wr(7'h60, 8'hf0);
      wr(7'h66, 8'h1f);
      wait_row(32);
      check("icon_row", 63'h1, seg);
      t_text(-1);
   endtask

   task automatic t_cursor();
      dctl_i <= '{1'b1, 1'b1, 1'b0};
      load_ac(7'h01);
      t_text(1);
      load_ac(7'h45);
      t_text(5);
      dctl_i <= '{1'b1, 1'b0, 1'b0};
   endtask

   task automatic t_reset_pin();
      int n;
      @(posedge ref_clk_i);
      reset_pin_n_i <= 1'b0;
      repeat (RM - 4) @(posedge ref_clk_i);
      reset_pin_n_i <= 1'b1;
      repeat (6) @(negedge ref_clk_i);
      check("short_pulse_busy", 63'h0, 63'(busy));
      @(posedge ref_clk_i);
      reset_pin_n_i <= 1'b0;
      repeat (RM + 6) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check("pin_busy", 63'h1, 63'(busy));
      wr(7'h02, 8'h02);
      @(posedge ref_clk_i);
      reset_pin_n_i <= 1'b1;
      wait_busy(n);
      check("pin_busy_len", 63'h1, 63'(n >= IB && n <= IB + 6));
      check("ac_cleared", 63'h0, 63'(ac));
      for (int c = 0; c < 12; c++) ddr[c] = 8'h20;
      t_text(-1);
   endtask

   // *********************************
   // clock, watchdog, main
   // *********************************
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      #(100 * 40000);
      miscompares++;
      summarize();
   end

   initial begin
      miscompares = 0;
      checks_done = 0;
      rst_n_i = 1'b0;
      reset_pin_n_i = 1'b1;
      ac_load_i = 1'b0;
      ac_value_i = 7'h00;
      host_wr_i = '0;
      dctl_i = '{1'b1, 1'b0, 1'b0};
      repeat (8) @(posedge ref_clk_i);
      t_power_up();
      t_font();
      t_icons();
      t_cursor();
      t_reset_pin();
      summarize();
   end
endmodule // lcd_ram_map_cursor_init_test
